// >>> rtl/umaf_defines.vh
/*
 Register offsets, field positions, reset values and codes for the
 multidrop serial port with receive address filtering.
 Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
// Functional notes
// - Filtering on drops frames lacking address marking
// - Five to eight bits: first stop is type
// - Nine bits: ninth data bit is type
// - Type one means address, zero means data
// - Transmitter ignores the filtering enable bit
// - Accepted address frame stored, sets receive complete
// - Data address: write transmits, read receives
// - Short characters: upper bits ignored, read zero
// - Write while buffer full is ignored
// - Buffered data moves to empty shifter, shifts
// - Two-entry receive FIFO advances on each data read while not empty
// - Status layout bits seven down to zero
// - Receive complete tracks unread data; disable flushes
// - Transmit complete clears by writing one
// - Transmit buffer empty is one after reset
`ifndef UMAF_DEFINES_VH
`define UMAF_DEFINES_VH

`define UMAF_OFS_DATA 8'h00
`define UMAF_OFS_STAT 8'h04
`define UMAF_OFS_CTRL 8'h08
`define UMAF_OFS_BAUD 8'h0c

`define UMAF_ST_RXC 7
`define UMAF_ST_TXC 6
`define UMAF_ST_TBE 5
`define UMAF_ST_FE 4
`define UMAF_ST_DOR 3
`define UMAF_ST_PE 2
`define UMAF_ST_DS 1
`define UMAF_ST_AFE 0

`define UMAF_CT_RXEN 0
`define UMAF_CT_TXEN 1
`define UMAF_CT_CSZ_LO 2
`define UMAF_CT_CSZ_HI 4
`define UMAF_CT_SBS 5
`define UMAF_CT_PM_LO 6
`define UMAF_CT_PM_HI 7
`define UMAF_CT_TX9 8
`define UMAF_CT_RX9 9

`define UMAF_CTRL_RESET 10'h000
`define UMAF_BAUD_RESET 12'h000
`define UMAF_CSZ_NINE 3'h7
`define UMAF_PM_EVEN 2'h2
`define UMAF_PM_ODD 2'h3
`define UMAF_OS_NORMAL 5'h10
`define UMAF_OS_DOUBLE 5'h08

`endif

// >>> rtl/umaf_uart.v
/*
 Asynchronous serial port with multidrop address filtering on receive,
 a shared data port, a two-entry receive FIFO and a status register.
 Assumes a classic Wishbone master on a 10 MHz clock, synchronous
 active-high reset and a serial input already synchronous to clk_i.
*/
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`include "umaf_defines.vh"

module umaf_uart #(
  parameter BAUD_W = 12
) (
  input wire clk_i,            // System clock
  input wire rst_i,            // Synchronous reset, active high
  input wire wb_cyc_i,         // Bus cycle
  input wire wb_stb_i,         // Bus strobe
  input wire wb_we_i,          // Write enable
  input wire [7:0] wb_adr_i,   // Byte address
  input wire [3:0] wb_sel_i,   // Byte lane selects
  input wire [31:0] wb_dat_i,  // Write data
  output reg [31:0] wb_dat_o,  // Read data
  output reg wb_ack_o,         // Acknowledge
  input wire serial_rx_line_i, // Serial receive line
  output reg serial_tx_line_o  // Serial transmit line
);

  localparam [5:0] RX_IDLE = 6'h01;
  localparam [5:0] RX_START = 6'h02;
  localparam [5:0] RX_DATA = 6'h04;
  localparam [5:0] RX_PAR = 6'h08;
  localparam [5:0] RX_STOP = 6'h10;
  localparam [5:0] RX_HOLD = 6'h20;
  localparam [5:0] TX_IDLE = 6'h01;
  localparam [5:0] TX_START = 6'h02;
  localparam [5:0] TX_DATA = 6'h04;
  localparam [5:0] TX_PAR = 6'h08;
  localparam [5:0] TX_STOP1 = 6'h10;
  localparam [5:0] TX_STOP2 = 6'h20;

  function [3:0] data_bits;
    input [2:0] csz;
    begin
      if (csz == `UMAF_CSZ_NINE)
        data_bits = 4'h9;
      else
        data_bits = {2'h0, csz[1:0]} + 4'h5;
    end
  endfunction

  function par_bit;
    input [8:0] d;
    input [1:0] pm;
    begin
      par_bit = (^d) ^ (pm == `UMAF_PM_ODD);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and bus slave
  reg [9:0] ctrl;
  reg [BAUD_W-1:0] baud_div;
  reg double_speed_sel;
  reg addr_filter_enable;
  reg tx_done_flag;
  reg overrun_flag;
  reg [8:0] tx_holding_buffer;
  reg tx_hold_valid;
  reg [8:0] rx_mem [0:1];
  reg rx_fe_mem [0:1];
  reg rx_pe_mem [0:1];
  reg rx_wp;
  reg rx_rp;
  reg [1:0] rx_count;

  wire rx_en = ctrl[`UMAF_CT_RXEN];
  wire tx_en = ctrl[`UMAF_CT_TXEN];
  wire [2:0] char_size_sel = ctrl[`UMAF_CT_CSZ_HI:`UMAF_CT_CSZ_LO];
  wire stop_bits_sel = ctrl[`UMAF_CT_SBS];
  wire [1:0] par_mode = ctrl[`UMAF_CT_PM_HI:`UMAF_CT_PM_LO];
  wire tx_ninth_bit = ctrl[`UMAF_CT_TX9];
  wire nine_mode = (char_size_sel == `UMAF_CSZ_NINE);
  wire [3:0] nbits = data_bits(char_size_sel);
  wire [8:0] mask = 9'h1ff >> (4'h9 - nbits);
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_req = bus_req & wb_we_i;
  wire rd_req = bus_req & ~wb_we_i;
  wire data_wr = wr_req & (wb_adr_i == `UMAF_OFS_DATA) & wb_sel_i[0];
  wire data_rd = rd_req & (wb_adr_i == `UMAF_OFS_DATA);
  wire stat_wr = wr_req & (wb_adr_i == `UMAF_OFS_STAT) & wb_sel_i[0];
  wire ctrl_wr = wr_req & (wb_adr_i == `UMAF_OFS_CTRL);
  wire baud_wr = wr_req & (wb_adr_i == `UMAF_OFS_BAUD);
  wire rx_done_flag = (rx_count != 2'h0);
  wire [8:0] rx_head = rx_mem[rx_rp];
  wire [7:0] status = {rx_done_flag, tx_done_flag, ~tx_hold_valid,
                       rx_done_flag & rx_fe_mem[rx_rp], overrun_flag,
                       rx_done_flag & rx_pe_mem[rx_rp], double_speed_sel,
                       addr_filter_enable};

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (wb_adr_i)
      `UMAF_OFS_DATA: rd_mux = {24'h0, rx_head[7:0]};
      `UMAF_OFS_STAT: rd_mux = {24'h0, status};
      `UMAF_OFS_CTRL: rd_mux = {22'h0, rx_head[8], ctrl[8:0]};
      `UMAF_OFS_BAUD: rd_mux = {{(32-BAUD_W){1'b0}}, baud_div};
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      if (rd_req)
        wb_dat_o <= rd_mux;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `UMAF_CTRL_RESET;
      baud_div <= `UMAF_BAUD_RESET;
      double_speed_sel <= 1'b0;
      addr_filter_enable <= 1'b0;
    end else begin
      if (ctrl_wr && wb_sel_i[0])
        ctrl[7:0] <= wb_dat_i[7:0];
      if (ctrl_wr && wb_sel_i[1])
        ctrl[8] <= wb_dat_i[8];
      if (baud_wr && wb_sel_i[0])
        baud_div[7:0] <= wb_dat_i[7:0];
      if (baud_wr && wb_sel_i[1])
        baud_div[BAUD_W-1:8] <= wb_dat_i[BAUD_W-1:8];
      if (stat_wr) begin
        double_speed_sel <= wb_dat_i[`UMAF_ST_DS];
        addr_filter_enable <= wb_dat_i[`UMAF_ST_AFE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Baud tick, oversampled 16x or 8x
  reg [BAUD_W-1:0] baud_cnt;
  reg os_tick;
  wire [4:0] os_len = double_speed_sel ? `UMAF_OS_DOUBLE : `UMAF_OS_NORMAL;

  always @(posedge clk_i) begin
    if (rst_i) begin
      baud_cnt <= {BAUD_W{1'b0}};
      os_tick <= 1'b0;
    end else if (baud_cnt >= baud_div) begin
      baud_cnt <= {BAUD_W{1'b0}};
      os_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 1'b1;
      os_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver
  reg [5:0] rx_state;
  reg [4:0] rx_os;
  reg [3:0] rx_idx;
  reg [8:0] rx_shift;
  reg rx_par_err;
  reg rx_stop;
  wire rx_mid = os_tick && (rx_os == os_len - 5'h1);
  wire rx_pop = data_rd & rx_done_flag;
  wire frame_is_addr = nine_mode ? rx_shift[8] : rx_stop;
  wire frame_keep = ~addr_filter_enable | frame_is_addr;
  wire frame_end = (rx_state == RX_HOLD);
  wire rx_push = frame_end & frame_keep & (rx_count != 2'h2);
  wire rx_ovr = frame_end & frame_keep & (rx_count == 2'h2);
  always @(posedge clk_i) begin
    if (rst_i || !rx_en) begin
      rx_state <= RX_IDLE;
      rx_os <= 5'h0;
      rx_idx <= 4'h0;
      rx_shift <= 9'h0;
      rx_par_err <= 1'b0;
      rx_stop <= 1'b0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_os <= 5'h0;
          if (!serial_rx_line_i)
            rx_state <= RX_START;
        end
        RX_START: begin
          if (os_tick) begin
            if (rx_os == {1'b0, os_len[4:1]} - 5'h1) begin
              rx_os <= 5'h0;
              rx_idx <= 4'h0;
              rx_shift <= 9'h0;
              rx_state <= serial_rx_line_i ? RX_IDLE : RX_DATA;
            end else begin
              rx_os <= rx_os + 5'h1;
            end
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_os <= 5'h0;
            rx_shift[rx_idx] <= serial_rx_line_i;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1)
              rx_state <= (par_mode[1]) ? RX_PAR : RX_STOP;
          end else if (os_tick) begin
            rx_os <= rx_os + 5'h1;
          end
        end
        RX_PAR: begin
          if (rx_mid) begin
            rx_os <= 5'h0;
            rx_par_err <= par_bit(rx_shift, par_mode) != serial_rx_line_i;
            rx_state <= RX_STOP;
          end else if (os_tick) begin
            rx_os <= rx_os + 5'h1;
          end
        end
        RX_STOP: begin
          if (rx_mid) begin
            rx_stop <= serial_rx_line_i;
            rx_state <= RX_HOLD;
          end else if (os_tick) begin
            rx_os <= rx_os + 5'h1;
          end
        end
        RX_HOLD: begin
          rx_par_err <= 1'b0;
          rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || !rx_en) begin
      rx_wp <= 1'b0;
      rx_rp <= 1'b0;
      rx_count <= 2'h0;
      overrun_flag <= 1'b0;
      rx_mem[0] <= 9'h0;
      rx_mem[1] <= 9'h0;
      rx_fe_mem[0] <= 1'b0;
      rx_fe_mem[1] <= 1'b0;
      rx_pe_mem[0] <= 1'b0;
      rx_pe_mem[1] <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= rx_shift & mask;
        rx_fe_mem[rx_wp] <= ~rx_stop;
        rx_pe_mem[rx_wp] <= rx_par_err;
        rx_wp <= ~rx_wp;
      end
      if (rx_pop)
        rx_rp <= ~rx_rp;
      rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
      if (rx_ovr)
        overrun_flag <= 1'b1;
      else if (rx_pop)
        overrun_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter, independent of the filtering enable
  reg [5:0] tx_state;
  reg [4:0] tx_os;
  reg [3:0] tx_idx;
  reg [8:0] tx_shift;
  wire tx_bit_end = os_tick && (tx_os == os_len - 5'h1);
  wire tx_load = tx_en && tx_hold_valid && (tx_state == TX_IDLE);
  wire tx_finish = tx_bit_end &&
    ((tx_state == TX_STOP2) || (tx_state == TX_STOP1 && !stop_bits_sel));
  wire txc_clr = stat_wr & wb_dat_i[`UMAF_ST_TXC];

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_holding_buffer <= 9'h0;
      tx_hold_valid <= 1'b0;
    end else begin
      if (data_wr && !tx_hold_valid) begin
        tx_holding_buffer <= {tx_ninth_bit, wb_dat_i[7:0]} & mask;
        tx_hold_valid <= 1'b1;
      end else if (tx_load) begin
        tx_hold_valid <= 1'b0;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_done_flag <= 1'b0;
    end else if (tx_finish && !tx_hold_valid) begin
      tx_done_flag <= 1'b1;
    end else if (txc_clr) begin
      tx_done_flag <= 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_state <= TX_IDLE;
      tx_os <= 5'h0;
      tx_idx <= 4'h0;
      tx_shift <= 9'h0;
      serial_tx_line_o <= 1'b1;
    end else begin
      if (tx_state != TX_IDLE && os_tick)
        tx_os <= tx_bit_end ? 5'h0 : tx_os + 5'h1;
      case (tx_state)
        TX_IDLE: begin
          serial_tx_line_o <= 1'b1;
          if (tx_load) begin
            tx_shift <= tx_holding_buffer;
            tx_idx <= 4'h0;
            serial_tx_line_o <= 1'b0;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            serial_tx_line_o <= tx_shift[0];
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_idx <= tx_idx + 4'h1;
            if (tx_idx == nbits - 4'h1) begin
              if (par_mode[1]) begin
                serial_tx_line_o <= par_bit(tx_shift, par_mode);
                tx_state <= TX_PAR;
              end else begin
                serial_tx_line_o <= 1'b1;
                tx_state <= TX_STOP1;
              end
            end else begin
              serial_tx_line_o <= tx_shift[tx_idx + 4'h1];
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            serial_tx_line_o <= 1'b1;
            tx_state <= TX_STOP1;
          end
        end
        TX_STOP1: begin
          if (tx_bit_end)
            tx_state <= stop_bits_sel ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: begin
          if (tx_bit_end)
            tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

endmodule

// >>> test/umaf_sva.sv
/*
 Checker for the serial port: bus handshake, status layout, readback.
 Assumes the master writes with all lane selects set.
*/
`timescale 1ns/1ns
module umaf_sva (
  input wire clk_i,            // Clock
  input wire rst_i,            // Reset
  input wire wb_cyc_i,         // Cycle
  input wire wb_stb_i,         // Strobe
  input wire wb_we_i,          // Write
  input wire [7:0] wb_adr_i,   // Address
  input wire [3:0] wb_sel_i,   // Selects
  input wire [31:0] wb_dat_i,  // Write data
  input wire [31:0] wb_dat_o,  // Read data
  input wire wb_ack_o,         // Acknowledge
  input wire serial_rx_line_i, // Line in
  input wire serial_tx_line_o  // Line out
);
  reg [9:0] ctrl;
  reg [1:0] stat;
  reg fresh;
  wire wr = wb_ack_o && wb_we_i;
  wire rd = wb_ack_o && !wb_we_i;
  wire st_rd = rd && wb_adr_i == 8'h04;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of what software wrote
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= 10'h000;
      stat <= 2'h0;
      fresh <= 1'b1;
    end else if (wr && wb_adr_i == 8'h08) begin
      ctrl <= wb_dat_i[9:0];
    end else if (wr && wb_adr_i == 8'h04) begin
      stat <= wb_dat_i[1:0];
    end else if (wr && wb_adr_i == 8'h00) begin
      fresh <= 1'b0;
    end
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence first_tx_s;
    wr && wb_adr_i == 8'h00 && ctrl[1] && fresh;
  endsequence
  ack_latency_a: assert property (req_s |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  tx_start_a: assert property (first_tx_s |-> ##[0:40] !serial_tx_line_o)
    else $error("no start bit after data write");
  tbe_reset_a: assert property (st_rd && fresh |-> wb_dat_o[5])
    else $error("tx buffer empty clear after reset");
  stat_rw_a: assert property (st_rd |-> wb_dat_o[1:0] == stat)
    else $error("status rw bits differ");
  stat_width_a: assert property (st_rd |-> wb_dat_o[31:8] == 24'h0)
    else $error("status upper bits set");
  rx_flush_a: assert property (st_rd && !ctrl[0] |-> !wb_dat_o[7])
    else $error("rx done set while receiver off");
  short_char_a: assert property (rd && wb_adr_i == 8'h00 &&
    ctrl[4:2] == 3'h0 |-> wb_dat_o[31:5] == 27'h0)
    else $error("short char upper bits set");
endmodule

bind umaf_uart umaf_sva umaf_sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_rx_line_i(serial_rx_line_i), .serial_tx_line_o(serial_tx_line_o)
);

// >>> test/umaf_node.sv
/*
 Far-side node on the shared serial line: sends frames, collects bytes.
 Assumes a fixed number of clocks per bit and eight-bit frames out.
*/
`timescale 1ns/1ns
module umaf_node #(
  parameter BIT_CLKS = 16
) (
  input wire clk_i,  // Clock
  input wire tx_i,   // Line from the port
  output reg line_o  // Line to the port
);
  logic [7:0] got[$];
  logic [7:0] d8;
  int i;
  initial line_o = 1'b1;
  task automatic bit_out(input logic b);
    line_o <= b;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask
  task automatic send(input int n, input logic [8:0] d, input logic typ);
    int k;
    bit_out(1'b0);
    for (k = 0; k < n; k++) bit_out(k == 8 ? typ : d[k]);
    if (n < 9) bit_out(typ);
    bit_out(1'b1);
  endtask
  always begin
    @(negedge tx_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      d8[i] = tx_i;
    end
    got.push_back(d8);
    repeat (BIT_CLKS) @(posedge clk_i);
  end
endmodule

// >>> test/test_uart_multidrop_addr_filter.sv
/*
 Testbench: register tasks over the bus, frames from a far-side node.
 Assumes baud divider 0, so one bit lasts 16 clocks.
*/
`timescale 1ns/1ns
module test_uart_multidrop_addr_filter;
  logic clk, rst, cyc, stb, we, ack, txl, rxl;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, q;
  int miscompares, cmp_count, n;
  umaf_uart umaf_uart_i (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .serial_rx_line_i(rxl),
    .serial_tx_line_o(txl)
  );
  umaf_node umaf_node_i (.clk_i(clk), .tx_i(txl), .line_o(rxl));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wb(input logic w, input [7:0] a, input [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    // Waits for ack; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input [7:0] a, input [31:0] e, input string what);
    wb(1'b0, a, 32'h0);
    chk(what, e, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    miscompares++;
    test_done();
  end
  initial begin
    clk = 0; rst = 1; cyc = 0; stb = 0; we = 0;
    adr = 8'h00; sel = 4'hf; dw = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h04, 32'h20, "reset status");
    $display("test reset done");
    wb(1'b1, 8'h08, 32'h1f);
    wb(1'b1, 8'h04, 32'h01);
    umaf_node_i.send(9, 9'h0c3, 1'b0);
    rd(8'h04, 32'h21, "status data dropped");
    umaf_node_i.send(9, 9'h05a, 1'b1);
    rd(8'h04, 32'ha1, "status address kept");
    rd(8'h08, 32'h21f, "ninth bit");
    rd(8'h00, 32'h5a, "address byte");
    rd(8'h04, 32'h21, "status popped");
    $display("test nine bit filter done");
    wb(1'b1, 8'h04, 32'h00);
    umaf_node_i.send(9, 9'h033, 1'b0);
    umaf_node_i.send(9, 9'h044, 1'b0);
    rd(8'h00, 32'h33, "first data");
    rd(8'h00, 32'h44, "second data");
    rd(8'h04, 32'h20, "status drained");
    $display("test selected slave done");
    wb(1'b1, 8'h08, 32'h03);
    wb(1'b1, 8'h04, 32'h01);
    umaf_node_i.send(5, 9'h01f, 1'b0);
    rd(8'h04, 32'h21, "short data dropped");
    umaf_node_i.send(5, 9'h0f5, 1'b1);
    rd(8'h00, 32'h15, "short char");
    umaf_node_i.send(5, 9'h00a, 1'b1);
    wb(1'b1, 8'h08, 32'h02);
    rd(8'h04, 32'h21, "flushed");
    $display("test short frames done");
    wb(1'b1, 8'h08, 32'h0e);
    wb(1'b1, 8'h00, 32'ha5);
    wb(1'b1, 8'h00, 32'h3c);
    rd(8'h04, 32'h01, "tx buffer full");
    wb(1'b1, 8'h00, 32'h99);
    for (n = 0; n < 2000 && umaf_node_i.got.size() < 2; n++) @(posedge clk);
    repeat (300) @(posedge clk);
    chk("frames sent", 32'h2, umaf_node_i.got.size());
    chk("first frame", 32'ha5, umaf_node_i.got[0]);
    chk("second frame", 32'h3c, umaf_node_i.got[1]);
    rd(8'h04, 32'h61, "tx done");
    wb(1'b1, 8'h04, 32'hff);
    rd(8'h04, 32'h23, "status write");
    wb(1'b1, 8'h04, 32'h00);
    $display("test transmit done");
    wb(1'b1, 8'h08, 32'h1f);
    umaf_node_i.send(9, 9'h011, 1'b0);
    umaf_node_i.send(9, 9'h022, 1'b0);
    wb(1'b1, 8'h04, 32'h01);
    umaf_node_i.send(9, 9'h0c3, 1'b0);
    rd(8'h04, 32'ha1, "full data dropped");
    umaf_node_i.send(9, 9'h0a5, 1'b1);
    rd(8'h04, 32'ha9, "overrun");
    rd(8'h00, 32'h11, "oldest kept");
    rd(8'h04, 32'ha1, "overrun cleared");
    rd(8'h00, 32'h22, "second kept");
    $display("test overrun done");
    wb(1'b1, 8'h04, 32'h00);
    wb(1'b1, 8'h08, 32'h8f);
    umaf_node_i.send(8, 9'h003, 1'b1);
    rd(8'h04, 32'ha4, "parity error");
    rd(8'h00, 32'h03, "parity data");
    wb(1'b1, 8'h08, 32'h03);
    umaf_node_i.send(5, 9'h00a, 1'b0);
    rd(8'h04, 32'hb0, "frame error");
    rd(8'h00, 32'h0a, "frame data");
    rd(8'h04, 32'h20, "errors cleared");
    $display("test error flags done");
    test_done();
  end
endmodule
